/* shared/sdg_map.svh */
`ifndef SDG_MAP_SVH
`define SDG_MAP_SVH

// Register indices; the byte address is four times the index
`define SDG_IDX_GAIN_DIV      8'h34
`define SDG_IDX_EXIT_THR      8'h35
`define SDG_IDX_CONTROL       8'h36
`define SDG_IDX_STATUS        8'h37
`define SDG_IDX_EFF_GAIN      8'h38

// Reset values
`define SDG_RST_GAIN_DIV      8'h00
`define SDG_RST_EXIT_THR      8'hFF
`define SDG_RST_CONTROL       8'h00

// Gain divider field positions
`define SDG_KI_SEL_MSB        6
`define SDG_KI_SEL_LSB        4
`define SDG_KP_SEL_MSB        2
`define SDG_KP_SEL_LSB        0

// Control field positions
`define SDG_CTL_SRC_BIT       0
`define SDG_CTL_LVL_MSB       7
`define SDG_CTL_LVL_LSB       4

// Divider select codes, named by divisor
`define SDG_DIV32             3'h0
`define SDG_DIV64             3'h1
`define SDG_DIV128            3'h2
`define SDG_DIV256            3'h3
`define SDG_DIV512            3'h4
`define SDG_DIV16             3'h5
`define SDG_DIV1              3'h6

// Gain widths: raw gain and fractional bits of the scaled result
`define SDG_RAW_W             7
`define SDG_FRAC_W            9
`define SDG_EFF_W             16

// Exit threshold scale: one code step is 2 Hz, measured over half a second
`define SDG_HZ_PER_CODE       2
`define SDG_CLK_HZ            20000000
`define SDG_WINDOW_CYCLES     (`SDG_CLK_HZ / `SDG_HZ_PER_CODE)
`define SDG_WIN_W             24

// Microstep level limits
`define SDG_LVL_MAX           4'h8
`define SDG_STEP_W            11
`define SDG_MEAS_W            9

`endif

/* shared/sdg_pkg.sv */
`include "sdg_map.svh"

package sdg_pkg;

    // Measurement window phases
    typedef enum logic {
        WIN_COUNT,
        WIN_DECIDE
    } sdg_win_t;

    // Whole state of the configuration block
    typedef struct packed {
        logic [7:0]                gainDiv;
        logic [7:0]                exitThr;
        logic                      resFromReg;
        logic [3:0]                regLevel;
        sdg_win_t                  win;
        logic [`SDG_WIN_W-1:0]     winCnt;
        logic [`SDG_STEP_W-1:0]    stepCnt;
        logic [`SDG_MEAS_W-1:0]    cycCnt;
        logic [`SDG_MEAS_W-1:0]    measured;
        logic                      stepPrev;
        logic                      silentActive;
        logic [3:0]                levelOut;
        logic [31:0]               prdata;
        logic                      pslverr;
    } sdg_state_t;

    // State of one gain scaler
    typedef struct packed {
        logic [`SDG_EFF_W-1:0] eff;
    } sdg_scale_state_t;

endpackage : sdg_pkg

/* shared/sdg_gain_if.sv */
`timescale 1ns/1ps
`include "sdg_map.svh"

// Carries one raw gain and its divider select to a scaler, and the result back
interface sdg_gain_if;
    logic [`SDG_RAW_W-1:0] raw;   // Raw gain
    logic [2:0]            sel;   // Divider select code
    logic [`SDG_EFF_W-1:0] eff;   // Scaled gain, fixed point

    modport ctrl   (output raw, output sel, input eff);
    modport scaler (input raw, input sel, output eff);
endinterface : sdg_gain_if

/* hdl/sdg_gain_scaler.sv */
`timescale 1ns/1ps
`include "sdg_map.svh"

module sdg_gain_scaler (
    input  wire logic            clk_sys,   // System clock
    input  wire logic            resetn,    // Async reset, active low
    sdg_gain_if.scaler           gain       // Raw gain in, scaled gain out
);
    import sdg_pkg::*;

    sdg_scale_state_t state;
    sdg_scale_state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // Shift amount per divider code; 111 has no meaning, kept undivided
    function automatic logic [3:0] shiftOf(input logic [2:0] sel);
        case (sel)
            `SDG_DIV32:  shiftOf = 4'h5;   // RULE1 RULE3
            `SDG_DIV64:  shiftOf = 4'h6;   // RULE1 RULE3
            `SDG_DIV128: shiftOf = 4'h7;   // RULE1 RULE3
            `SDG_DIV256: shiftOf = 4'h8;   // RULE2 RULE3
            `SDG_DIV512: shiftOf = 4'h9;   // RULE1 RULE3
            `SDG_DIV16:  shiftOf = 4'h4;   // RULE2 RULE3
            `SDG_DIV1:   shiftOf = 4'h0;   // RULE1 RULE3
            default:     shiftOf = 4'h0;
        endcase
    endfunction : shiftOf

    ////////////////////////////////////////////////////////////////////////
    // Raw gain gets fraction bits appended so small quotients are not lost
    always_comb begin
        logic [`SDG_EFF_W-1:0] wide;
        wide = {gain.raw, {`SDG_FRAC_W{1'b0}}};
        next_state.eff = wide >> shiftOf(gain.sel);   // RULE11
    end

    // Result register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign gain.eff = state.eff;

endmodule : sdg_gain_scaler

/* hdl/sdg_top.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "sdg_map.svh"
//
// Overview of operation
// RULE1: Integral gain divided by code at bits 6-4: /32,/64,/128,/512, undivided.
// RULE2: Integral code 011 divides by 256, 101 by 16; 111 unspecified.
// RULE3: Proportional gain divided per 3-bit code: /32 to /512, /16, undivided.
// RULE4: Above the 8-bit frequency threshold, leave silent decay for general decay.
// RULE5: Threshold code is 2 Hz per count, 255 meaning 510 Hz.
// RULE6: Host never writes threshold zero.
// RULE7: Gain divider register resets to 00h.
// RULE8: Exit threshold register resets to FFh.
// RULE9: Host drives a square wave on step at the microstep rate.
// RULE10: Microstep level comes from pins or register field, applied to indexer.
// RULE11: Dividers are right shifts by 4 to 9, or none.

module sdg_top #(
    parameter int WINDOW_CYCLES = `SDG_WINDOW_CYCLES   // Half-second gate
) (
    input  wire logic                  clk_sys,             // System clock 20 MHz
    input  wire logic                  resetn,              // Async reset, active low
    input  wire logic                  psel,                // APB select
    input  wire logic                  penable,             // APB enable
    input  wire logic                  pwrite,              // APB write
    input  wire logic [11:0]           paddr,               // APB byte address
    input  wire logic [31:0]           pwdata,              // APB write data
    output logic      [31:0]           prdata,              // APB read data
    output logic                       pready,              // APB ready
    output logic                       pslverr,             // APB error
    input  wire logic [`SDG_RAW_W-1:0] rawIntegralGain,     // Raw integral gain
    input  wire logic [`SDG_RAW_W-1:0] rawProportionalGain, // Raw proportional gain
    input  wire logic                  silentEnable,        // Silent decay enabled
    input  wire logic [2:0]            generalDecay,        // General decay setting
    input  wire logic                  stepIn,              // Step pulse input
    input  wire logic                  resolutionPinLow,    // Mode pin, low bit
    input  wire logic                  resolutionPinHigh,   // Mode pin, high bit
    output logic      [`SDG_EFF_W-1:0] effIntegralGain,     // Scaled integral gain
    output logic      [`SDG_EFF_W-1:0] effProportionalGain, // Scaled proportional gain
    output logic                       silentDecayActive,   // Silent decay in use
    output logic      [2:0]            appliedDecay,        // Decay when not silent
    output logic      [3:0]            microstepLevel       // Log2 microsteps per step
);
    import sdg_pkg::*;

    localparam logic [`SDG_WIN_W-1:0] WIN_LAST = `SDG_WIN_W'(WINDOW_CYCLES - 1);

    sdg_state_t state;
    sdg_state_t next_state;

    sdg_gain_if kiBus ();
    sdg_gain_if kpBus ();

    ////////////////////////////////////////////////////////////////////////
    // Word index decode; low two address bits must be zero
    function automatic logic [7:0] indexOf(input logic [11:0] addr);
        indexOf = addr[9:2];
    endfunction : indexOf

    // Pin code to level: full, half, quarter, sixteenth
    function automatic logic [3:0] pinLevel(input logic hi, input logic lo);
        case ({hi, lo})
            2'h0:    pinLevel = 4'h0;
            2'h1:    pinLevel = 4'h1;
            2'h2:    pinLevel = 4'h2;
            default: pinLevel = 4'h4;
        endcase
    endfunction : pinLevel

    // Last step count of one electrical cycle: four full steps per sine period
    function automatic logic [`SDG_STEP_W-1:0] stepsLast(input logic [3:0] lvl);
        logic [3:0] l;
        l = (lvl > `SDG_LVL_MAX) ? `SDG_LVL_MAX : lvl;
        stepsLast = (`SDG_STEP_W'(4) << l) - `SDG_STEP_W'(1);
    endfunction : stepsLast

    ////////////////////////////////////////////////////////////////////////
    // Gain scalers, one per loop term
    assign kiBus.raw = rawIntegralGain;
    assign kiBus.sel = state.gainDiv[`SDG_KI_SEL_MSB:`SDG_KI_SEL_LSB];     // RULE1
    assign kpBus.raw = rawProportionalGain;
    assign kpBus.sel = state.gainDiv[`SDG_KP_SEL_MSB:`SDG_KP_SEL_LSB];     // RULE3

    sdg_gain_scaler uKi (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .gain    (kiBus)
    );

    sdg_gain_scaler uKp (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .gain    (kpBus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: APB registers, level select, frequency gate
    always_comb begin
        logic        setup;
        logic        access;
        logic [7:0]  idx;
        logic        aligned;
        logic        stepRise;
        logic [3:0]  lvl;
        logic        cycDone;
        lvl      = 4'h0;
        cycDone  = 1'b0;
        setup    = psel && !penable;
        access   = psel && penable;
        idx      = indexOf(paddr);
        aligned  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
        stepRise = stepIn && !state.stepPrev;
        next_state = state;

        // Level to the indexer, from pins or the register field
        lvl = state.resFromReg ? state.regLevel
                               : pinLevel(resolutionPinHigh, resolutionPinLow); // RULE10
        next_state.levelOut = lvl;                                              // RULE10

        // Read data and error are prepared in setup so they come from flops
        if (setup) begin
            next_state.prdata  = 32'h0000_0000;
            next_state.pslverr = 1'b0;
            if (!aligned) begin
                next_state.pslverr = 1'b1;
            end else begin
                case (idx)
                    `SDG_IDX_GAIN_DIV: next_state.prdata[7:0] = state.gainDiv;
                    `SDG_IDX_EXIT_THR: next_state.prdata[7:0] = state.exitThr;
                    `SDG_IDX_CONTROL: begin
                        next_state.prdata[`SDG_CTL_SRC_BIT] = state.resFromReg;
                        next_state.prdata[`SDG_CTL_LVL_MSB:`SDG_CTL_LVL_LSB] =
                            state.regLevel;
                    end
                    `SDG_IDX_STATUS: begin
                        next_state.prdata[0]     = state.silentActive;
                        next_state.prdata[7:4]   = state.levelOut;
                        next_state.prdata[16:8]  = state.measured;
                    end
                    `SDG_IDX_EFF_GAIN:
                        next_state.prdata = {kpBus.eff, kiBus.eff};
                    default: next_state.pslverr = 1'b1;
                endcase
            end
        end

        // Writes take effect at the access edge; reserved divider bits are stored, reserved control bits dropped
        if (access && pwrite && aligned) begin
            case (idx)
                `SDG_IDX_GAIN_DIV: next_state.gainDiv = pwdata[7:0];           // RULE1 RULE3
                `SDG_IDX_EXIT_THR: next_state.exitThr = pwdata[7:0];           // RULE4
                `SDG_IDX_CONTROL: begin
                    next_state.resFromReg = pwdata[`SDG_CTL_SRC_BIT];          // RULE10
                    next_state.regLevel   = pwdata[`SDG_CTL_LVL_MSB:`SDG_CTL_LVL_LSB];
                end
                default: ;
            endcase
        end

        // Count step edges into electrical cycles of the coil current
        next_state.stepPrev = stepIn;
        if (stepRise) begin
            if (state.stepCnt >= stepsLast(lvl)) begin
                next_state.stepCnt = '0;
                cycDone            = 1'b1;
                if (state.cycCnt != {`SDG_MEAS_W{1'b1}}) begin
                    next_state.cycCnt = state.cycCnt + `SDG_MEAS_W'(1);
                end
            end else begin
                next_state.stepCnt = state.stepCnt + `SDG_STEP_W'(1);
            end
        end

        // Half-second gate: cycles counted equal frequency in 2 Hz codes
        case (state.win)
            WIN_COUNT: begin
                if (state.winCnt >= WIN_LAST) begin
                    next_state.winCnt = '0;
                    next_state.win    = WIN_DECIDE;
                end else begin
                    next_state.winCnt = state.winCnt + `SDG_WIN_W'(1);
                end
            end
            WIN_DECIDE: begin
                // Gate closes: publish and restart; a step edge here is kept
                next_state.measured = state.cycCnt;                            // RULE5
                next_state.cycCnt   = {{(`SDG_MEAS_W-1){1'b0}}, cycDone};
                next_state.win      = WIN_COUNT;
                next_state.winCnt   = `SDG_WIN_W'(1);
            end
            default: begin
                next_state.win    = WIN_COUNT;
                next_state.winCnt = '0;
            end
        endcase

        // Silent decay only while enabled and at or below the exit frequency
        next_state.silentActive = silentEnable &&
            (state.measured <= {1'b0, state.exitThr});                          // RULE4
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with documented reset values
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state            <= '0;
            state.gainDiv    <= `SDG_RST_GAIN_DIV;                              // RULE7
            state.exitThr    <= `SDG_RST_EXIT_THR;                              // RULE8
            state.win        <= WIN_COUNT;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; zero-wait slave, so ready is simply high
    assign pready              = 1'b1;
    assign prdata              = state.prdata;
    assign pslverr             = state.pslverr;
    assign effIntegralGain     = kiBus.eff;
    assign effProportionalGain = kpBus.eff;
    assign silentDecayActive   = state.silentActive;
    assign appliedDecay        = generalDecay;
    assign microstepLevel      = state.levelOut;

endmodule : sdg_top

/* bench/sdg_step_host.sv */
`timescale 1ns/1ps

// Host side of the step input: a square wave at a fixed microstep rate
module sdg_step_host (
    input  wire logic       clk_sys, // System clock
    input  wire logic       resetn,  // Async reset, active low
    input  wire logic [7:0] halfPer, // Half period in cycles, 0 stops
    output logic            stepOut  // Step pulse train
);
    logic [7:0] cnt; // Cycles into the half period

    // Toggle every halfPer cycles; idle low so a stop leaves no stray edge
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt <= 8'h00;
            stepOut <= 1'b0;
        end else if (halfPer == 8'h00) begin
            cnt <= 8'h00;
            stepOut <= 1'b0;
        end else if (cnt + 8'h01 >= halfPer) begin
            cnt <= 8'h00;
            stepOut <= ~stepOut;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : sdg_step_host

/* bench/sdg_chk_sva.sv */
`timescale 1ns/1ps

module sdg_chk (
    input wire logic        clk_sys, resetn, psel, penable, pwrite, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [6:0]  rawIntegralGain, rawProportionalGain,
    input wire logic        silentEnable, silentDecayActive,
    input wire logic        resolutionPinLow, resolutionPinHigh,
    input wire logic [2:0]  generalDecay, appliedDecay,
    input wire logic [15:0] effIntegralGain, effProportionalGain,
    input wire logic [3:0]  microstepLevel
);
    logic [1:0] live; // Edges since reset, saturating
    logic [7:0] div;  // Shadow of the gain divider
    logic       src;  // Shadow of the level source bit
    logic       dW;   // Divider written since reset
    logic       tW;   // Threshold written since reset
    logic       wr;   // Write takes effect at this edge
    assign wr = psel && penable && pwrite;

    function automatic logic [3:0] sh(input logic [2:0] c);
        if (c == 3'h5) return 4'h4;
        if (c > 3'h5) return 4'h0;
        return 4'h5 + {1'b0, c};
    endfunction : sh

    // Shadow registers track what software wrote
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            live <= 2'h0;
            div <= 8'h00;
            src <= 1'b0;
            dW <= 1'b0;
            tW <= 1'b0;
        end else begin
            if (live != 2'h3) live <= live + 2'h1;
            if (wr && paddr == 12'h0D0) div <= pwdata[7:0];
            if (wr && paddr == 12'h0D0) dW <= 1'b1;
            if (wr && paddr == 12'h0D4) tW <= 1'b1;
            if (wr && paddr == 12'h0D8) src <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_set;
        psel && !penable;
    endsequence
    sequence s_rd(a);
        s_set ##0 !pwrite && paddr == a;
    endsequence

    property p_rst_div;
        s_rd(12'h0D0) ##0 !dW |=> prdata == 32'h0;
    endproperty
    a_rst_div: assert property (p_rst_div) else $error("divider reset value");
    property p_rst_thr;
        s_rd(12'h0D4) ##0 !tW |=> prdata == 32'hFF;
    endproperty
    a_rst_thr: assert property (p_rst_thr) else $error("threshold reset value");
    property p_ki;
        live == 2'h3 |-> effIntegralGain ==
            ({$past(rawIntegralGain), 9'h000} >> sh($past(div[6:4])));
    endproperty
    a_ki: assert property (p_ki) else $error("integral gain scaling");
    property p_kp;
        live == 2'h3 |-> effProportionalGain ==
            ({$past(rawProportionalGain), 9'h000} >> sh($past(div[2:0])));
    endproperty
    a_kp: assert property (p_kp) else $error("proportional gain scaling");
    property p_dec;
        appliedDecay == generalDecay;
    endproperty
    a_dec: assert property (p_dec) else $error("fallback decay mode");
    property p_off;
        !silentEnable |=> !silentDecayActive;
    endproperty
    a_off: assert property (p_off) else $error("silent decay while disabled");
    property p_pins;
        live == 2'h3 && !$past(src) |-> microstepLevel == ($past(resolutionPinHigh)
            ? {1'b0, $past(resolutionPinLow), ~$past(resolutionPinLow), 1'b0}
            : {3'h0, $past(resolutionPinLow)});
    endproperty
    a_pins: assert property (p_pins) else $error("level from pins");
    property p_err;
        s_set ##0 paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("misaligned access accepted");
endmodule : sdg_chk

bind sdg_top sdg_chk sdg_chk_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .rawIntegralGain(rawIntegralGain), .rawProportionalGain(rawProportionalGain),
    .silentEnable(silentEnable), .silentDecayActive(silentDecayActive),
    .resolutionPinLow(resolutionPinLow), .resolutionPinHigh(resolutionPinHigh),
    .generalDecay(generalDecay), .appliedDecay(appliedDecay), .effIntegralGain(effIntegralGain),
    .effProportionalGain(effProportionalGain), .microstepLevel(microstepLevel));

/* bench/silent_decay_gain_threshold_bench.sv */
`timescale 1ns/1ps
`include "sdg_map.svh"

module silent_decay_gain_threshold_bench;
    // Byte addresses: four times each register index
    localparam logic [11:0] A_DIV = {2'h0, `SDG_IDX_GAIN_DIV, 2'h0};
    localparam logic [11:0] A_THR = {2'h0, `SDG_IDX_EXIT_THR, 2'h0};
    localparam logic [11:0] A_CTL = {2'h0, `SDG_IDX_CONTROL, 2'h0};
    localparam logic [11:0] A_STS = {2'h0, `SDG_IDX_STATUS, 2'h0};
    localparam logic [11:0] A_EFF = {2'h0, `SDG_IDX_EFF_GAIN, 2'h0};

    logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  rawI, rawP;
    logic        silentEnable, stepIn, pinLo, pinHi, silentDecayActive;
    logic [2:0]  generalDecay, appliedDecay;
    logic [15:0] effI, effP;
    logic [3:0]  microstepLevel;
    logic [7:0]  halfPer;
    int          err_total, checked, cyc;

    sdg_top #(.WINDOW_CYCLES(200)) sdg_top_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rawIntegralGain(rawI), .rawProportionalGain(rawP),
        .silentEnable(silentEnable), .generalDecay(generalDecay), .stepIn(stepIn),
        .resolutionPinLow(pinLo), .resolutionPinHigh(pinHi), .effIntegralGain(effI),
        .effProportionalGain(effP), .silentDecayActive(silentDecayActive),
        .appliedDecay(appliedDecay), .microstepLevel(microstepLevel));
    sdg_step_host sdg_step_host_i (.clk_sys(clk_sys), .resetn(resetn), .halfPer(halfPer),
        .stepOut(stepIn));

    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the run needs well under 5000 cycles
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            stop_test();
        end
    end

    task stop_test;
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One APB transfer, then an idle edge so the next setup never lands on a release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for ready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Expected scaled gain: codes 0..4 shift 5..9, 5 shifts 4, 6 none
    function automatic logic [15:0] ex(input logic [2:0] c, input logic [6:0] r);
        return {r, 9'h000} >> (c == 3'h5 ? 4 : (c == 3'h6 ? 0 : 5 + c));
    endfunction : ex

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clk_sys, resetn, psel, penable, pwrite, paddr, pwdata, pinLo, pinHi} = '0;
        {halfPer, err_total, checked, cyc} = '0;
        rawI = 7'h5B;
        rawP = 7'h3D;
        silentEnable = 1'b1;
        generalDecay = 3'h5;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, A_DIV, 32'h0);
        chk("divider reset", 32'h0, rd);
        apb(1'b0, A_THR, 32'h0);
        chk("threshold reset", 32'hFF, rd);
        chk("silent after reset", 32'h1, {31'h0, silentDecayActive});
        chk("fallback decay", 32'h5, {29'h0, appliedDecay});
        for (int c = 0; c < 7; c++) begin
            apb(1'b1, A_DIV, {24'h0, 1'b0, 3'(c), 1'b0, 3'(c)});
            apb(1'b0, A_DIV, 32'h0);
            chk("divider readback", {24'h0, 1'b0, 3'(c), 1'b0, 3'(c)}, rd);
            chk("integral gain", {16'h0, ex(3'(c), rawI)}, {16'h0, effI});
            chk("proportional gain", {16'h0, ex(3'(c), rawP)}, {16'h0, effP});
        end
        apb(1'b1, 12'h100, 32'hFFFF);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b0, A_DIV + 12'h001, 32'h0);
        chk("misaligned error", 32'h1, {31'h0, er});
        apb(1'b0, A_DIV, 32'h0);
        chk("divider kept", 32'h66, rd);
        apb(1'b0, A_EFF, 32'h0);
        chk("scaled gain word", {ex(3'h6, rawP), ex(3'h6, rawI)}, rd);
        for (int p = 0; p < 4; p++) begin
            {pinHi, pinLo} <= 2'(p);
            repeat (3) @(posedge clk_sys);
            chk("pin level", (p == 3) ? 32'h4 : p, {28'h0, microstepLevel});
        end
        apb(1'b1, A_CTL, 32'h31);
        repeat (2) @(posedge clk_sys);
        chk("register level", 32'h3, {28'h0, microstepLevel});
        {pinHi, pinLo} <= 2'h0;
        apb(1'b1, A_CTL, 32'h0);
        // Full step at 100 edges per gate gives about 25 counts; thresholds sit off the edge
        halfPer <= 8'h01;
        apb(1'b1, A_THR, 32'd23);
        repeat (450) @(posedge clk_sys);
        chk("fast exits silent", 32'h0, {31'h0, silentDecayActive});
        apb(1'b1, A_THR, 32'd27);
        repeat (450) @(posedge clk_sys);
        chk("slow stays silent", 32'h1, {31'h0, silentDecayActive});
        apb(1'b0, A_STS, 32'h0);
        chk("status low byte", 32'h1, rd & 32'h0000_00FF);
        chk("measured code", 32'h1, {31'h0, rd[16:8] > 9'd23 && rd[16:8] <= 9'd27});
        silentEnable <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("silent disabled", 32'h0, {31'h0, silentDecayActive});
        stop_test();
    end
endmodule : silent_decay_gain_threshold_bench
